// ---- logic/cdpp_top.sv ----
// Purpose: Post-processing of channels 9 to 12: gain and offset on channel 12, lane test
//          patterns for lanes 9 to 12 and a shared digital high-pass filter.
// Assumes: Samples come from logic on the same clock; a plain register port with read data
//          in the cycle after the read strobe.
// Notes:   Latency from sample strobe to lane strobe is three cycles.
// Summary of operation
// - Channel 12 gain acts only while the global gain enable is one.
// - Gain code N in bits 15 to 11 gives N times 0.2 dB.
// - With global offset enable set, the 10-bit channel 12 offset is added.
// - With per-lane selection set, bits 15 to 12 enable the pattern on lanes 9-12.
// - With per-lane selection set, lanes 9 and 10 use their 3-bit codes.
// - Bit 0 enables the high-pass filter on channels 9 to 12; off after reset.
// - When enabled, k comes from bits 4 to 1, shared by all four channels.
// - Output is 2^k/(2^k+1) times input minus last input plus last output.
// - The offset is twos complement with bit 9 as its sign.
module cdpp_top
  import cdpp_pkg::*;
(
  input  wire logic                                 clock_i,               // System clock.
  input  wire logic                                 rst_i,                 // Sync reset.
  input  wire logic [ADDR_W-1:0]                    reg_addr_i,            // Register offset.
  input  wire logic [DATA_W-1:0]                    reg_wdata_i,           // Write data.
  input  wire logic                                 reg_wr_i,              // Write strobe.
  input  wire logic                                 reg_rd_i,              // Read strobe.
  output logic      [DATA_W-1:0]                    reg_rdata_o,           // Read data.
  input  wire logic                                 sample_valid_i,        // Sample strobe.
  input  wire logic [CDPP_LANES-1:0][SAMPLE_W-1:0]  sample_i,              // Channels 9-12.
  output logic                                      lane_valid_o,          // Lane strobe.
  output logic      [CDPP_LANES-1:0][SAMPLE_W-1:0]  lane_data_o,           // Lanes 9-12.
  output logic      [2:0]                           lane9_pattern_code_o,  // Lane 9 code.
  output logic      [2:0]                           lane10_pattern_code_o  // Lane 10 code.
);
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  // Configuration state.
  logic                        global_gain_apply;
  logic                        global_offset_apply;
  logic                        per_lane_pattern_choice;
  logic [DATA_W-1:0]           ch12_gain_and_offset;
  logic [DATA_W-1:0]           ch12_offset_duplicate;
  logic [DATA_W-1:0]           lanes9_12_pattern_and_highpass;

  // Register decode.
  logic                        hit_global;
  logic                        hit_pattern;
  logic                        hit_go;
  logic                        hit_dup;
  logic                        hit_lane;
  logic [DATA_W-1:0]           global_view;
  logic [DATA_W-1:0]           pattern_view;
  logic [DATA_W-1:0]           read_value;
  logic [DATA_W-1:0]           next_rdata;

  assign hit_global  = reg_hit(reg_addr_i, REG_GLOBAL_OFF);
  assign hit_pattern = reg_hit(reg_addr_i, REG_PATTERN_OFF);
  assign hit_go      = reg_hit(reg_addr_i, REG_CH12_GO_OFF);
  assign hit_dup     = reg_hit(reg_addr_i, REG_CH12_DUP_OFF);
  assign hit_lane    = reg_hit(reg_addr_i, REG_LANE_OFF);

  assign global_view  = (DATA_W'(global_gain_apply) << GAIN_APPLY_BIT)
                      | (DATA_W'(global_offset_apply) << OFFSET_APPLY_BIT);
  assign pattern_view = DATA_W'(per_lane_pattern_choice) << PATTERN_IND_BIT;

  // Unmapped offsets read as zero.
  assign read_value = ({DATA_W{hit_global}}  & global_view)
                    | ({DATA_W{hit_pattern}} & pattern_view)
                    | ({DATA_W{hit_go}}      & ch12_gain_and_offset)
                    | ({DATA_W{hit_dup}}     & ch12_offset_duplicate)
                    | ({DATA_W{hit_lane}}    & lanes9_12_pattern_and_highpass);
  assign next_rdata = reg_rd_i ? read_value : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      global_gain_apply   <= 1'b0;
      global_offset_apply <= 1'b0;
    end else if (reg_wr_i && hit_global) begin
      global_gain_apply   <= reg_wdata_i[GAIN_APPLY_BIT];
      global_offset_apply <= reg_wdata_i[OFFSET_APPLY_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) per_lane_pattern_choice <= 1'b0;
    else if (reg_wr_i && hit_pattern) per_lane_pattern_choice <= reg_wdata_i[PATTERN_IND_BIT];
  end

  // Reserved bits are dropped on write, so they always read back as zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ch12_gain_and_offset           <= REG_RESET;
      ch12_offset_duplicate          <= REG_RESET;
      lanes9_12_pattern_and_highpass <= REG_RESET;
    end else if (reg_wr_i) begin
      if (hit_go) ch12_gain_and_offset <= reg_wdata_i & CH12_GO_MASK;
      if (hit_dup) ch12_offset_duplicate <= reg_wdata_i & CH12_DUP_MASK;
      if (hit_lane) lanes9_12_pattern_and_highpass <= reg_wdata_i & LANE_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) reg_rdata_o <= '0;
    else reg_rdata_o <= next_rdata;
  end

  // Field views.
  logic        [4:0]            twelfth_channel_gain_code;
  logic        [OFFSET_W-1:0]   twelfth_channel_offset_value;
  logic        [CDPP_LANES-1:0] lane_prbs_on;
  logic        [2:0]            lane9_pattern_code;
  logic        [2:0]            lane10_pattern_code;
  logic        [3:0]            highpass_k_group;
  logic                         highpass_on_group;

  assign twelfth_channel_gain_code = ch12_gain_and_offset[GAIN_CODE_LSB +: 5];
  // The duplicate copy is kept for read-back only; the datapath trusts the first copy.
  assign twelfth_channel_offset_value = ch12_gain_and_offset[OFFSET_W-1:0];
  assign lane9_pattern_code  = lanes9_12_pattern_and_highpass[LANE9_CODE_LSB +: 3];
  assign lane10_pattern_code = lanes9_12_pattern_and_highpass[LANE10_CODE_LSB +: 3];
  assign highpass_k_group    = lanes9_12_pattern_and_highpass[HP_K_LSB +: 4];
  assign highpass_on_group   = lanes9_12_pattern_and_highpass[HP_ON_BIT];

  for (genvar i = 0; i < CDPP_LANES; i++) begin : g_prbs_bits
    assign lane_prbs_on[i] = lanes9_12_pattern_and_highpass[LANE9_PRBS_BIT - i];
  end

  // Channel 12 gain and offset.
  logic signed [SAMPLE_W-1:0]   ch12_in;
  logic        [11:0]           gain_factor;
  logic signed [WIDE_W-1:0]     gain_prod;
  logic signed [WIDE_W-1:0]     gain_sel;
  logic signed [WIDE_W-1:0]     offset_ext;
  logic signed [WIDE_W-1:0]     offset_sel;
  logic signed [SAMPLE_W-1:0]   ch12_adjusted;

  assign ch12_in     = sample_i[CDPP_LANES-1];
  assign gain_factor = GAIN_LUT[twelfth_channel_gain_code];
  assign gain_prod   = (WIDE_W'(ch12_in) * WIDE_W'($signed({1'b0, gain_factor})))
                       >>> GAIN_FRAC;
  assign gain_sel    = global_gain_apply ? gain_prod : WIDE_W'(ch12_in);
  assign offset_ext  = WIDE_W'($signed(twelfth_channel_offset_value));
  assign offset_sel  = global_offset_apply ? offset_ext : '0;
  // Saturate once after both steps, so a large gain cannot wrap before the offset lands.
  assign ch12_adjusted = cdpp_sat(gain_sel + offset_sel);

  // Stages.
  cdpp_smp_if stage_if [CDPP_LANES] ();
  cdpp_smp_if hpf_if   [CDPP_LANES] ();

  for (genvar i = 0; i < CDPP_LANES; i++) begin : g_chan
    logic signed [SAMPLE_W-1:0] next_stage;

    assign next_stage = (i == CDPP_LANES - 1) ? ch12_adjusted : sample_i[i];

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        stage_if[i].valid <= 1'b0;
        stage_if[i].data  <= '0;
      end else begin
        stage_if[i].valid <= sample_valid_i;
        if (sample_valid_i) stage_if[i].data <= next_stage;
      end
    end

    cdpp_hpf u_hpf (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .on_i    (highpass_on_group),
      .k_i     (highpass_k_group),
      .in_s    (stage_if[i]),
      .out_s   (hpf_if[i])
    );
  end

  // Lane selection.
  logic        [SAMPLE_W-1:0]   prbs_word;
  logic        [CDPP_LANES-1:0] prbs_sel;
  logic        [SAMPLE_W-1:0]   next_lane [CDPP_LANES];
  logic                         out_step;
  logic        [2:0]            next_code9;
  logic        [2:0]            next_code10;

  assign out_step = hpf_if[0].valid;

  cdpp_prbs u_prbs (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .step_i  (out_step),
    .word_o  (prbs_word)
  );

  for (genvar i = 0; i < CDPP_LANES; i++) begin : g_lane
    assign prbs_sel[i]  = per_lane_pattern_choice & lane_prbs_on[i];
    assign next_lane[i] = prbs_sel[i] ? prbs_word : hpf_if[i].data;
  end

  assign next_code9  = per_lane_pattern_choice ? lane9_pattern_code : 3'h0;
  assign next_code10 = per_lane_pattern_choice ? lane10_pattern_code : 3'h0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lane_valid_o <= 1'b0;
      lane_data_o  <= '0;
    end else begin
      lane_valid_o <= out_step;
      for (int i = 0; i < CDPP_LANES; i++) begin
        if (out_step) lane_data_o[i] <= next_lane[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lane9_pattern_code_o  <= 3'h0;
      lane10_pattern_code_o <= 3'h0;
    end else begin
      lane9_pattern_code_o  <= next_code9;
      lane10_pattern_code_o <= next_code10;
    end
  end

  // Checks.
  sequence plain_take_s;
    sample_valid_i && !global_gain_apply && !global_offset_apply;
  endsequence

  sequence gain_take_s;
    sample_valid_i && global_gain_apply && !global_offset_apply;
  endsequence

  sequence offset_take_s;
    sample_valid_i && !global_gain_apply && global_offset_apply;
  endsequence

  sequence chain_s;
    sample_valid_i && !highpass_on_group && !per_lane_pattern_choice ##1
    !highpass_on_group ##1 !per_lane_pattern_choice;
  endsequence

  gain_off_pass_a: assert property (@(posedge clock_i) disable iff (rst_i)
    plain_take_s |=> stage_if[3].data == $past(ch12_in))
    else $error("channel 12 changed with gain and offset off");

  unity_code_a: assert property (@(posedge clock_i) disable iff (rst_i)
    gain_take_s ##0 twelfth_channel_gain_code == 5'h00 |=> stage_if[3].data == $past(ch12_in))
    else $error("gain code zero was not unity");

  gain_code_a: assert property (@(posedge clock_i) disable iff (rst_i)
    gain_take_s ##0 twelfth_channel_gain_code == 5'h1e ##0 ch12_in == 14'h0400
    |=> stage_if[3].data == 14'h07fb)
    else $error("gain code thirty did not give six dB");

  offset_add_a: assert property (@(posedge clock_i) disable iff (rst_i)
    offset_take_s ##0 ch12_in == 14'h0000
    |=> stage_if[3].data == SAMPLE_W'($past(offset_ext)))
    else $error("offset was not added to channel 12");

  offset_sign_a: assert property (@(posedge clock_i) disable iff (rst_i)
    offset_take_s ##0 ch12_in == 14'h0010 ##0 twelfth_channel_offset_value == 10'h3ff
    |=> stage_if[3].data == 14'h000f)
    else $error("offset sign bit not honoured");

  prbs_lane_a: assert property (@(posedge clock_i) disable iff (rst_i)
    out_step && prbs_sel[0] |=> lane_data_o[0] == $past(prbs_word))
    else $error("lane 9 did not carry the pattern");

  prbs_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    out_step && !per_lane_pattern_choice |=> lane_data_o[3] == $past(hpf_if[3].data))
    else $error("pattern shown without per-lane selection");

  lane_code_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 lane9_pattern_code_o == ($past(per_lane_pattern_choice) ? $past(lane9_pattern_code) : 3'h0)
    && lane10_pattern_code_o == ($past(per_lane_pattern_choice) ? $past(lane10_pattern_code) : 3'h0))
    else $error("lane pattern code mismatch");

  hp_reset_a: assert property (@(posedge clock_i)
    rst_i |=> !highpass_on_group && highpass_k_group == 4'h0)
    else $error("filter not disabled after reset");

  bypass_chain_a: assert property (@(posedge clock_i) disable iff (rst_i)
    chain_s |=> lane_valid_o && lane_data_o[0] == $past(sample_i[0], 3))
    else $error("disabled filter chain did not pass channel 9");

  read_once_a: assert property (@(posedge clock_i) disable iff (rst_i)
    reg_rd_i && hit_lane |=> reg_rdata_o[HP_K_LSB +: 4] == $past(highpass_k_group)
    ##1 ($past(reg_rd_i) || reg_rdata_o == '0))
    else $error("read data wrong or held too long");
endmodule

// ---- pkg/cdpp_pkg.sv ----
// Purpose: Shared constants, register map and helpers of the channel 9 to 12 post-processor.
// Assumes: 14-bit twos-complement samples, one clock, registers at their printed offsets.
// Notes:   Register fields that other blocks own are not stored here.
package cdpp_pkg;
  localparam int          CDPP_LANES = 4;
  localparam int          SAMPLE_W   = 14;
  localparam int          WIDE_W     = 28;
  localparam int          ACC_W      = 20;
  localparam int          COEF_W     = 17;
  localparam int          COEF_FRAC  = 16;
  localparam int          GAIN_FRAC  = 10;
  localparam int          ADDR_W     = 6;
  localparam int          DATA_W     = 16;

  localparam logic [5:0]  REG_GLOBAL_OFF   = 6'h03;
  localparam logic [5:0]  REG_PATTERN_OFF  = 6'h04;
  localparam logic [5:0]  REG_CH12_GO_OFF  = 6'h2b;
  localparam logic [5:0]  REG_CH12_DUP_OFF = 6'h2c;
  localparam logic [5:0]  REG_LANE_OFF     = 6'h2d;

  localparam int          GAIN_APPLY_BIT   = 12;
  localparam int          OFFSET_APPLY_BIT = 8;
  localparam int          PATTERN_IND_BIT  = 8;
  localparam int          GAIN_CODE_LSB    = 11;
  localparam int          OFFSET_W         = 10;
  localparam int          LANE9_PRBS_BIT   = 15;
  localparam int          LANE9_CODE_LSB   = 9;
  localparam int          LANE10_CODE_LSB  = 6;
  localparam int          HP_K_LSB         = 1;
  localparam int          HP_ON_BIT        = 0;

  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] CH12_GO_MASK   = 16'hfbff;
  localparam logic [15:0] CH12_DUP_MASK  = 16'h03ff;
  localparam logic [15:0] LANE_MASK      = 16'hffdf;
  localparam logic [14:0] PRBS_SEED      = 15'h7fff;

  // Linear factor 10^(N*0.2/20) in steps of 1/1024, index N.
  localparam logic [11:0] GAIN_LUT [32] = '{
    12'h400, 12'h418, 12'h430, 12'h449, 12'h463, 12'h47d, 12'h498, 12'h4b3,
    12'h4cf, 12'h4ec, 12'h509, 12'h527, 12'h546, 12'h565, 12'h586, 12'h5a6,
    12'h5c8, 12'h5eb, 12'h60e, 12'h632, 12'h657, 12'h67d, 12'h6a3, 12'h6cb,
    12'h6f4, 12'h71d, 12'h747, 12'h773, 12'h79f, 12'h7cd, 12'h7fb, 12'h82b};

  function automatic logic signed [SAMPLE_W-1:0] cdpp_sat(input logic signed [WIDE_W-1:0] v);
    logic signed [WIDE_W-1:0] hi;
    logic signed [WIDE_W-1:0] lo;
    hi = WIDE_W'(8191);
    lo = -WIDE_W'(8192);
    if (v > hi) cdpp_sat = 14'h1fff;
    else if (v < lo) cdpp_sat = 14'h2000;
    else cdpp_sat = v[SAMPLE_W-1:0];
  endfunction
endpackage

// ---- pkg/cdpp_smp_if.sv ----
// Purpose: One sample stream between stages: a valid strobe and a signed word.
// Assumes: Valid is a one-cycle pulse beside its data.
// Notes:   No back-pressure; the sink takes every strobed word.
interface cdpp_smp_if;
  import cdpp_pkg::*;
  logic                       valid;
  logic signed [SAMPLE_W-1:0] data;
  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface

// ---- logic/cdpp_prbs.sv ----
// Purpose: Pseudo-random word source for the lane test pattern.
// Assumes: One shift of a 15-bit maximal-length register per step.
// Notes:   All lanes that select the pattern see the same word.
module cdpp_prbs
  import cdpp_pkg::*;
(
  input  wire logic                clock_i, // System clock.
  input  wire logic                rst_i,   // Synchronous reset.
  input  wire logic                step_i,  // Advance one position.
  output logic     [SAMPLE_W-1:0]  word_o   // Current pattern word.
);
  logic [14:0] state;
  logic [14:0] next_state;

  assign next_state = {state[13:0], state[14] ^ state[13]};
  assign word_o     = state[SAMPLE_W-1:0];

  always_ff @(posedge clock_i) begin
    if (rst_i) state <= PRBS_SEED;
    else if (step_i) state <= next_state;
  end

  never_stuck_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state != 15'h0000) else $error("pattern register fell to zero");
endmodule

// ---- logic/cdpp_hpf.sv ----
// Purpose: First-order high-pass on one channel, factor 2^k/(2^k+1).
// Assumes: k arrives as a 4-bit code; the host keeps it within 2 to 10.
// Notes:   Disabling the filter clears its history so a later enable starts clean.
module cdpp_hpf
  import cdpp_pkg::*;
(
  input  wire logic         clock_i, // System clock.
  input  wire logic         rst_i,   // Synchronous reset.
  input  wire logic         on_i,    // Filter enabled.
  input  wire logic [3:0]   k_i,     // Filter parameter k.
  cdpp_smp_if.snk           in_s,    // Samples in.
  cdpp_smp_if.src           out_s    // Samples out, one cycle later.
);
  logic        [COEF_W-1:0]     coef_tab [16];
  logic signed [SAMPLE_W-1:0]   x_prev;
  logic signed [ACC_W-1:0]      y_prev;
  logic signed [ACC_W-1:0]      sum;
  logic signed [ACC_W+COEF_W:0] prod;
  logic signed [ACC_W-1:0]      y_now;
  logic signed [SAMPLE_W-1:0]   next_out;

  // Fixed-point 2^k/(2^k+1) avoids a divider at the cost of one rounding per sample.
  for (genvar g = 0; g < 16; g++) begin : g_coef
    localparam longint unsigned NUM = 64'h1 << (COEF_FRAC + g);
    localparam longint unsigned DEN = (64'h1 << g) + 64'h1;
    assign coef_tab[g] = COEF_W'((NUM + DEN / 2) / DEN);
  end

  assign sum      = ACC_W'(in_s.data) - ACC_W'(x_prev) + y_prev;
  assign prod     = sum * $signed({1'b0, coef_tab[k_i]});
  assign y_now    = ACC_W'(prod >>> COEF_FRAC);
  assign next_out = on_i ? cdpp_sat(WIDE_W'(y_now)) : in_s.data;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      x_prev     <= '0;
      y_prev     <= '0;
      out_s.data <= '0;
    end else if (!on_i) begin
      // History is cleared while off, with or without samples, so k changes made while off start clean.
      x_prev     <= '0;
      y_prev     <= '0;
      if (in_s.valid) out_s.data <= next_out;
    end else if (in_s.valid) begin
      x_prev     <= in_s.data;
      y_prev     <= y_now;
      out_s.data <= next_out;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) out_s.valid <= 1'b0;
    else out_s.valid <= in_s.valid;
  end

  bypass_path_a: assert property (@(posedge clock_i) disable iff (rst_i)
    in_s.valid && !on_i |=> out_s.data == $past(in_s.data))
    else $error("disabled filter altered the sample");
  zero_sum_a: assert property (@(posedge clock_i) disable iff (rst_i)
    in_s.valid && on_i && sum == '0 |=> out_s.data == '0 && y_prev == '0)
    else $error("zero filter sum gave nonzero output");
  coef_scale_a: assert property (@(posedge clock_i) disable iff (rst_i)
    in_s.valid && on_i && k_i == 4'h2 && sum == ACC_W'(500) |=> out_s.data == 14'h0190)
    else $error("k of two did not scale by four fifths");
endmodule

// ---- bench/cdpp_rx_model.sv ----
// Purpose: Lane receiver at the far side of the post-processor.
// Assumes: Words come with a one-cycle strobe and are never stalled.
// Notes:   The receiver has no back-pressure, so it only captures and counts.
module cdpp_rx_model
  import cdpp_pkg::*;
(
  input  wire logic                                clock_i, // System clock.
  input  wire logic                                rst_i,   // Sync reset.
  input  wire logic                                valid_i, // Word strobe.
  input  wire logic [CDPP_LANES-1:0][SAMPLE_W-1:0] data_i,  // Lanes 9-12.
  output logic      [CDPP_LANES-1:0][SAMPLE_W-1:0] word_o,  // Last word set.
  output int                                       count_o  // Words taken.
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      word_o  <= '0;
      count_o <= 0;
    end else if (valid_i) begin
      word_o  <= data_i;
      count_o <= count_o + 1;
    end
  end
endmodule

// ---- bench/cdpp_top_tb.sv ----
// Purpose: Self-checking bench of the channel 9 to 12 post-processor.
// Assumes: Read data stands in the cycle after the read strobe only.
// Notes:   Filter expectations come from a bench model that keeps its own history.
module cdpp_top_tb;
  import cdpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                clk = 1'b0;
  logic                                rst = 1'b1;
  logic [ADDR_W-1:0]                   addr = '0;
  logic [DATA_W-1:0]                   wdata = '0;
  logic                                wr = 1'b0;
  logic                                rd = 1'b0;
  logic [DATA_W-1:0]                   rdata;
  logic                                sv = 1'b0;
  logic [CDPP_LANES-1:0][SAMPLE_W-1:0] smp = '0;
  logic [CDPP_LANES-1:0][SAMPLE_W-1:0] v;
  logic [CDPP_LANES-1:0][SAMPLE_W-1:0] ld;
  logic [CDPP_LANES-1:0][SAMPLE_W-1:0] rx_word;
  logic                                lv;
  logic [2:0]                          code9;
  logic [2:0]                          code10;
  int                                  rx_count;
  int                                  errors = 0;
  int                                  cmp_count = 0;
  int                                  cycles = 0;
  int                                  xp [4];
  int                                  yp [4];
  logic [5:0]                          addrs [5] = '{6'h03, 6'h04, 6'h2b, 6'h2c, 6'h2d};
  logic [15:0]                         masks [5] =
    '{16'h1100, 16'h0100, 16'hfbff, 16'h03ff, 16'hffdf};
  always #5 clk = ~clk;
  cdpp_top u_cdpp_top (.clock_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_valid_i(sv), .sample_i(smp),
    .lane_valid_o(lv), .lane_data_o(ld), .lane9_pattern_code_o(code9),
    .lane10_pattern_code_o(code10));
  cdpp_rx_model u_cdpp_rx_model (.clock_i(clk), .rst_i(rst), .valid_i(lv), .data_i(ld),
    .word_o(rx_word), .count_o(rx_count));
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_lane(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: lane got %h expected %h", $time, got, exp);
    end
  endtask
  // Each access lets one edge pass after dropping its strobe, so strobes never collide.
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stands for this one cycle only, so it is taken mid-cycle.
    @(negedge clk);
    check_reg(rdata, exp);
    @(posedge clk);
  endtask
  task automatic send(input logic [3:0][13:0] s);
    int n;
    n = 0;
    smp <= s;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    while (lv !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    check_reg(16'(n), 16'h0003);
  endtask
  function automatic logic [13:0] hp(input int i, input int x, input int k);
    longint c;
    longint s;
    longint y;
    c = (longint'(131072) * (1 << k) + (1 << k) + 1) / (2 * ((1 << k) + 1));
    s = x - xp[i] + yp[i];
    y = (s * c) >>> 16;
    xp[i] = x;
    yp[i] = int'(y);
    return 14'(y);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd_reg(addrs[i], 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr_reg(addrs[i], 16'hffff);
      rd_reg(addrs[i], masks[i]);
      wr_reg(addrs[i], 16'h0000);
    end
    wr_reg(6'h10, 16'hffff);
    rd_reg(6'h10, 16'h0000);
    $display("test registers done");
    v = {4{14'h0400}};
    wr_reg(6'h2b, 16'hf000);
    send(v);
    check_lane(rx_word[3], v[3]);
    wr_reg(6'h03, 16'h1000);
    send(v);
    check_lane(rx_word[3], 14'h07fb);
    check_lane(rx_word[0], v[0]);
    wr_reg(6'h2b, 16'h0000);
    send(v);
    check_lane(rx_word[3], v[3]);
    $display("test gain done");
    wr_reg(6'h03, 16'h0100);
    wr_reg(6'h2b, 16'h03ff);
    wr_reg(6'h2c, 16'h03ff);
    v[3] = 14'h0010;
    send(v);
    check_lane(rx_word[3], 14'h000f);
    wr_reg(6'h2b, 16'h01ff);
    wr_reg(6'h2c, 16'h01ff);
    v[3] = 14'h0000;
    send(v);
    check_lane(rx_word[3], 14'h01ff);
    v[3] = 14'h0400;
    wr_reg(6'h03, 16'h0000);
    $display("test offset done");
    wr_reg(6'h2d, 16'h0ac0);
    @(posedge clk);
    check_reg({13'h0000, code9}, 16'h0000);
    wr_reg(6'h04, 16'h0100);
    @(posedge clk);
    check_reg({13'h0000, code9}, 16'h0005);
    check_reg({13'h0000, code10}, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wr_reg(6'h2d, 16'h8000 >> i);
      send(v);
      for (int m = 0; m < 4; m++) check_reg({15'h0000, rx_word[m] !== v[m]}, {15'h0000, m == i});
    end
    wr_reg(6'h04, 16'h0000);
    wr_reg(6'h2d, 16'hf000);
    send(v);
    for (int m = 0; m < 4; m++) check_lane(rx_word[m], v[m]);
    $display("test patterns done");
    for (int k = 2; k <= 10; k += 8) begin
      wr_reg(6'h2d, 16'h0000);
      wr_reg(6'h2d, 16'(k << 1) | 16'h0001);
      xp = '{default: 0};
      yp = '{default: 0};
      for (int j = 0; j < 3; j++) begin
        for (int i = 0; i < 4; i++) v[i] = 14'(500 * (i + 1) - 900 * j);
        send(v);
        for (int i = 0; i < 4; i++) check_lane(rx_word[i], hp(i, 500 * (i + 1) - 900 * j, k));
      end
    end
    wr_reg(6'h2d, 16'h0004);
    send(v);
    for (int m = 0; m < 4; m++) check_lane(rx_word[m], v[m]);
    $display("test filter done");
    check_reg(16'(rx_count), 16'h0011);
    end_sim();
  end
endmodule
